// File: testbench/dsr_supply_model.sv
// Model of the monitored supplies driving the three comparator pins
`timescale 1ns/1ns
module dsr_supply_model (
  // Clock
  input  wire logic       core_clk,
  // Commanded comparator levels and settle lag in cycles
  input  wire logic       want_a,
  input  wire logic       want_b,
  input  wire logic       want_sup,
  input  wire logic [3:0] lag,
  // Comparator pins toward the supervisor
  output logic            pin_a,
  output logic            pin_b,
  output logic            pin_sup
);
  logic [3:0] wait_cnt; // Cycles left before the pins settle

  // Rails start discharged
  initial begin
    pin_a    = 1'b0;
    pin_b    = 1'b0;
    pin_sup  = 1'b0;
    wait_cnt = 4'h0;
  end

  // A slow rail slews: pins move only once the lag has run out
  always @(posedge core_clk) begin
    if ({want_a, want_b, want_sup} == {pin_a, pin_b, pin_sup}) begin
      wait_cnt <= lag;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else begin
      pin_a   <= want_a;
      pin_b   <= want_b;
      pin_sup <= want_sup;
    end
  end
endmodule : dsr_supply_model

// File: testbench/tb.sv
// Self-checking bench for the dual supply reset supervisor
`timescale 1ns/1ns
module tb import dsr_pkg::*;;
  localparam int PROP_C = 4;   // Shortened comparator filter
  localparam int UV_C   = 4;   // Shortened lockout filter
  localparam int MIN_C  = 20;  // Shortened minimum timeout
  localparam int INT_C  = 50;  // Shortened internal timeout
  localparam int NF_C   = 10;  // Cycles per nanofarad

  logic        core_clk, reset;                  // Clock and reset
  logic        want_a, want_b, want_sup;         // Commanded rails
  logic [3:0]  slow;                             // Partner settle lag
  logic        pin_a, pin_b, pin_sup;            // Comparator pins
  logic [3:0]  reg_addr;                         // Register port
  logic [31:0] reg_wdata, reg_rdata, rdata_q;
  logic        reg_write, reg_read;
  logic        status_out_a, status_out_b, reset_out_n, irq;
  logic        pos_a, pos_b;                     // Expected polarities
  int          num_errors, num_checks, cyc, n;
  wire  [2:0]  outs = {reset_out_n, status_out_b, status_out_a};

  dsr_supply_model i_dsr_supply_model (.core_clk(core_clk), .want_a(want_a),
    .want_b(want_b), .want_sup(want_sup), .lag(slow), .pin_a(pin_a), .pin_b(pin_b),
    .pin_sup(pin_sup));

  dsr_supervisor #(.PROP_CYC(PROP_C), .UV_CYC(UV_C), .MIN_CYC(MIN_C), .INT_CYC(INT_C),
    .NF_CYC(NF_C)) i_dsr_supervisor (.core_clk(core_clk), .reset(reset),
    .monitor_input_a(pin_a), .monitor_input_b(pin_b), .supply_undervoltage_lockout(pin_sup),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .status_out_a(status_out_a), .status_out_b(status_out_b),
    .reset_out_n(reset_out_n), .irq(irq));

  // 250 MHz clock
  always #2 core_clk = ~core_clk;

  // Hang guard: far above the thousand or so cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  // Compare a seen value with the expected one
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One-cycle write strobe
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data stands only in the following cycle
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 rdata_q = reg_rdata;
  endtask : rd

  // Count cycles until an output reaches a level, bounded
  task wait_for(input int which, input logic val, input int max_c, output int cnt);
    cnt = 0;
    #1;
    while (cnt < max_c && outs[which] !== val) begin
      @(posedge core_clk);
      #1 cnt++;
    end
  endtask : wait_for

  // Check a measured delay lies in a window
  task in_range(input string what, input int v, input int lo, input int hi);
    check(what, 32'(v >= lo && v <= hi), 32'h1);
  endtask : in_range

  // Lockout, program mode and select, raise rails; optional glitch on A
  task power_up(input logic [1:0] mode, input logic [1:0] sel, input int glitch_at);
    @(posedge core_clk);
    want_sup <= 1'b0;
    repeat (16) @(posedge core_clk);
    wr(REG_CTRL, {28'h0, sel, mode});
    pos_a  = (sel != DSR_SEL_LOW);
    pos_b  = (sel == DSR_SEL_HIGH);
    want_a <= pos_a;
    want_b <= pos_b;
    @(posedge core_clk);
    want_sup <= 1'b1;
    if (glitch_at > 0) begin
      repeat (glitch_at) @(posedge core_clk);
      want_a <= ~pos_a;
      repeat (14) @(posedge core_clk);
      #1 check("reset_out_n aborted", reset_out_n, 1'b0);
      @(posedge core_clk);
      want_a <= pos_a;
    end
    wait_for(2, 1'b1, 200, n);
  endtask : power_up

  // Counts, verdict and end of run
  task results();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    core_clk = 1'b0; reset = 1'b1; want_a = 1'b0; want_b = 1'b0; want_sup = 1'b0;
    slow = 4'h0; reg_addr = 4'h0; reg_wdata = 32'h0; reg_write = 1'b0; reg_read = 1'b0;
    num_errors = 0; num_checks = 0; cyc = 0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    // Register reset values, unmapped index, capacitance setting
    rd(REG_CTRL);     check("ctrl", rdata_q, 32'h0);
    rd(REG_CAP);      check("cap", rdata_q, 32'h2);
    rd(REG_IRQ_MASK); check("mask", rdata_q, 32'h0);
    wr(4'h9, 32'hFFFFFFFF);
    rd(4'h9);         check("unmapped", rdata_q, 32'h0);
    wr(REG_CAP, 32'h4);
    rd(REG_CAP);      check("cap write", rdata_q, 32'h4);
    $display("test registers done");
    // Every select: polarities, per-input status and reset
    for (int s = 0; s < 3; s++) begin
      power_up(DSR_TMO_OPEN, 2'(s), 0);
      in_range("open timeout", n, MIN_C, MIN_C + 14);
      rd(REG_STATUS);
      check("status reg", rdata_q[4:0], {27'h0, pos_b, pos_a, 3'b111});
      @(posedge core_clk);
      want_a <= ~pos_a;
      wait_for(0, 1'b0, 40, n);
      in_range("delay a", n, PROP_C, PROP_C + 7);
      check("reset on a", reset_out_n, 1'b0);
      check("status b", status_out_b, 1'b1);
      @(posedge core_clk);
      want_a <= pos_a;
      want_b <= ~pos_b;
      wait_for(1, 1'b0, 40, n);
      check("status b low", status_out_b, 1'b0);
      wait_for(0, 1'b1, 40, n);
      check("status a back", status_out_a, 1'b1);
      check("reset on b", reset_out_n, 1'b0);
      @(posedge core_clk);
      want_b <= pos_b;
      wait_for(2, 1'b1, 100, n);
      in_range("rerelease", n, MIN_C, MIN_C + 14);
    end
    $display("test polarity done");
    // Timeout modes, comparator mode against a slow rail, glitch restart last
    power_up(DSR_TMO_INT, DSR_SEL_HIGH, 0);
    in_range("internal timeout", n, INT_C, INT_C + 14);
    power_up(DSR_TMO_EXT, DSR_SEL_HIGH, 0);
    in_range("ext timeout", n, 4 * NF_C, 4 * NF_C + 14);
    slow <= 4'h5;
    power_up(DSR_TMO_CMP, DSR_SEL_HIGH, 0);
    in_range("comparator mode", n, 0, 20);
    slow <= 4'h0;
    power_up(DSR_TMO_INT, DSR_SEL_HIGH, 25);
    in_range("restarted timeout", n, INT_C, INT_C + 14);
    $display("test timeout done");
    // Supply loss: lockout, sticky masked interrupt, read clear
    wr(REG_IRQ_MASK, 32'h4);
    rd(REG_IRQ_STAT);
    @(posedge core_clk);
    want_sup <= 1'b0;
    wait_for(2, 1'b0, 40, n);
    in_range("uv detect", n, UV_C, UV_C + 7);
    repeat (3) @(posedge core_clk);
    #1 check("status under lockout", outs, 3'b000);
    check("irq raised", irq, 1'b1);
    rd(REG_IRQ_STAT); check("supply lost", rdata_q[2], 1'b1);
    rd(REG_IRQ_STAT); check("stat cleared", rdata_q, 32'h0);
    repeat (2) @(posedge core_clk);
    #1 check("irq cleared", irq, 1'b0);
    $display("test lockout done");
    // Select change while supply good is ignored
    power_up(DSR_TMO_OPEN, DSR_SEL_LOW, 0);
    wr(REG_CTRL, {28'h0, DSR_SEL_HIGH, DSR_TMO_OPEN});
    repeat (10) @(posedge core_clk);
    rd(REG_STATUS);
    check("select held", rdata_q[4:2], 3'b001);
    $display("test select latch done");
    results();
  end
endmodule : tb

// File: verilog/dsr_filter.sv
// Delay filter: output follows input once stable for a cycle count
`timescale 1ns/1ns
module dsr_filter import dsr_pkg::*; #(
  parameter int unsigned DELAY = 1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Level in and delayed level out
  input  wire logic din,
  output logic      dout
);
  logic [CNT_W-1:0] cnt; // Cycles the input has differed from the output

  // Count while input differs, copy when the delay has run
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt  <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt <= '0;
    end else if (cnt >= CNT_W'(DELAY - 1)) begin
      cnt  <= '0;
      dout <= din;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule : dsr_filter

// File: verilog/dsr_pkg.sv
// Package of constants and types for the dual supply reset supervisor
package dsr_pkg;
  // Clock rate in kHz (250 MHz core clock)
  localparam int unsigned CLK_KHZ          = 250000;
  // Typical comparator propagation delay in microseconds
  localparam int unsigned PROP_DELAY_US    = 150;
  localparam int unsigned PROP_DELAY_CYC   = PROP_DELAY_US * CLK_KHZ / 1000;
  // Typical undervoltage detect delay in microseconds
  localparam int unsigned UV_DELAY_US      = 150;
  localparam int unsigned UV_DELAY_CYC     = UV_DELAY_US * CLK_KHZ / 1000;
  // Minimum timeout with the control left open, microseconds
  localparam int unsigned MIN_TIMEOUT_US   = 400;
  localparam int unsigned MIN_TIMEOUT_CYC  = MIN_TIMEOUT_US * CLK_KHZ / 1000;
  // Internal timeout in milliseconds
  localparam int unsigned INT_TIMEOUT_MS   = 200;
  localparam int unsigned INT_TIMEOUT_CYC  = INT_TIMEOUT_MS * CLK_KHZ;
  // External timeout scale in milliseconds per nanofarad
  localparam int unsigned EXT_MS_PER_NF    = 9;
  localparam int unsigned EXT_CYC_PER_NF   = EXT_MS_PER_NF * CLK_KHZ;
  // Width of timeout counters: holds the full capacitance range without wrap
  localparam int unsigned CNT_W            = 34;
  // Width of the capacitance setting in nanofarads
  localparam int unsigned CAP_W            = 12;
  // Register offsets
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_STATUS       = 4'h1;
  localparam logic [3:0]  REG_IRQ_STAT     = 4'h2;
  localparam logic [3:0]  REG_IRQ_MASK     = 4'h3;
  localparam logic [3:0]  REG_CAP          = 4'h4;
  // Control field positions
  localparam int unsigned CTRL_MODE_LSB    = 0;
  localparam int unsigned CTRL_SEL_LSB     = 2;
  // Reset values
  localparam logic [1:0]  MODE_RST         = 2'h0;
  localparam logic [1:0]  SEL_RST          = 2'h0;
  localparam logic [CAP_W-1:0] CAP_RST     = 12'h002;
  // Interrupt bit positions
  localparam int unsigned IRQ_A_BIT        = 0;
  localparam int unsigned IRQ_B_BIT        = 1;
  localparam int unsigned IRQ_UV_BIT       = 2;
  localparam int unsigned IRQ_RST_BIT      = 3;
  localparam int unsigned IRQ_W            = 4;

  // Timeout modes, as the timeout control pin states
  typedef enum logic [1:0] {
    DSR_TMO_INT  = 2'b00,   // Tied low: internal timeout
    DSR_TMO_EXT  = 2'b01,   // Capacitor attached: scaled timeout
    DSR_TMO_OPEN = 2'b10,   // Left open: minimum timeout
    DSR_TMO_CMP  = 2'b11    // Tied to supply: comparator mode
  } dsr_tmo_e;

  // Polarity select states
  typedef enum logic [1:0] {
    DSR_SEL_LOW  = 2'b00,   // Both inputs negative
    DSR_SEL_OPEN = 2'b01,   // A positive, B negative
    DSR_SEL_HIGH = 2'b10    // Both inputs positive
  } dsr_sel_e;

  // Reset sequencer states
  typedef enum logic [1:0] {
    DSR_ST_LOCK  = 2'b00,   // Supply below lockout
    DSR_ST_HOLD  = 2'b01,   // Waiting for all inputs valid
    DSR_ST_TIME  = 2'b10,   // Timeout running
    DSR_ST_RUN   = 2'b11    // Reset released
  } dsr_state_e;

  // Validity of one input given its comparator result and polarity
  function automatic logic dsr_valid(input logic above, input logic positive);
    return positive ? above : ~above;
  endfunction : dsr_valid
endpackage : dsr_pkg

// File: verilog/dsr_supervisor.sv
// Top of the dual supply reset supervisor with register port
// How it works
// - Status A low while input A invalid
// - Status B low while input B invalid
// - Reset asserted on any invalid input
// - Reset held for timeout after valid
// - External timeout scales with capacitance setting
// - Open control gives short minimum timeout
// - Tied low gives internal timeout
// - Tied high bypasses timer, comparator mode
// - Hysteresis only in comparator mode
// - Status follows input after propagation delay
// - Lockout asserts reset after detect delay
// - Supply lockout is third monitored condition
// - Select high/open/low sets input polarities
// - Latch polarity only below lockout threshold
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module dsr_supervisor import dsr_pkg::*; #(
  parameter int unsigned PROP_CYC = PROP_DELAY_CYC,
  parameter int unsigned UV_CYC   = UV_DELAY_CYC,
  parameter int unsigned MIN_CYC  = MIN_TIMEOUT_CYC,
  parameter int unsigned INT_CYC  = INT_TIMEOUT_CYC,
  parameter int unsigned NF_CYC   = EXT_CYC_PER_NF
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Comparator results from the analog side
  input  wire logic       monitor_input_a,
  input  wire logic       monitor_input_b,
  input  wire logic       supply_undervoltage_lockout,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [31:0]     reg_rdata,
  // Supervisor outputs
  output logic            status_out_a,
  output logic            status_out_b,
  output logic            reset_out_n,
  output logic            irq
);
  dsr_sync_if sync ();           // Synchronised comparator levels
  logic       filt_a;            // Delayed comparator A
  logic       filt_b;            // Delayed comparator B
  logic       filt_ok;           // Delayed supply good
  logic [1:0] timeout_control;   // Timeout mode setting
  logic [1:0] sel_pin;           // Polarity select setting
  logic [CAP_W-1:0] timing_capacitance; // External capacitance in nF
  logic       pos_a;             // Latched polarity of A
  logic       pos_b;             // Latched polarity of B
  logic       valid_a;           // Input A valid
  logic       valid_b;           // Input B valid
  logic       all_valid;         // Every condition valid
  logic       cmp_hold;          // Comparator-mode hysteresis state
  dsr_state_e state;             // Sequencer state
  logic [CNT_W-1:0] tmo_cnt;     // Timeout counter
  logic [CNT_W-1:0] tmo_len;     // Selected timeout length
  logic [IRQ_W-1:0] irq_stat;    // Sticky event bits
  logic [IRQ_W-1:0] irq_mask;    // Event enables
  logic [IRQ_W-1:0] events;      // Events this cycle
  logic       prev_a;            // Last status A
  logic       prev_b;            // Last status B
  logic       prev_ok;           // Last supply good
  logic       prev_rst;          // Last reset output

  dsr_sync u_sync (
    .core_clk      (core_clk),
    .reset         (reset),
    .above_a_pin   (monitor_input_a),
    .above_b_pin   (monitor_input_b),
    .supply_ok_pin (supply_undervoltage_lockout),
    .sync          (sync)
  );

  dsr_filter #(.DELAY(PROP_CYC)) u_filt_a (
    .core_clk (core_clk),
    .reset    (reset),
    .din      (sync.above_a),
    .dout     (filt_a)
  );

  dsr_filter #(.DELAY(PROP_CYC)) u_filt_b (
    .core_clk (core_clk),
    .reset    (reset),
    .din      (sync.above_b),
    .dout     (filt_b)
  );

  dsr_filter #(.DELAY(UV_CYC)) u_filt_uv (
    .core_clk (core_clk),
    .reset    (reset),
    .din      (sync.supply_ok),
    .dout     (filt_ok)
  );

  // Control register writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      timeout_control    <= MODE_RST;
      sel_pin            <= SEL_RST;
      timing_capacitance <= CAP_RST;
    end else if (reg_write && reg_addr == REG_CTRL) begin
      timeout_control <= reg_wdata[CTRL_MODE_LSB +: 2];
      sel_pin         <= reg_wdata[CTRL_SEL_LSB +: 2];
    end else if (reg_write && reg_addr == REG_CAP) begin
      timing_capacitance <= reg_wdata[CAP_W-1:0];
    end
  end

  // Tracking while low and freezing when good acts as a latch at the rise
  // latch polarity only while supply is below lockout
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pos_a <= 1'b0;
      pos_b <= 1'b0;
    end else if (!filt_ok) begin
      case (sel_pin)
        DSR_SEL_HIGH: begin
          pos_a <= 1'b1;
          pos_b <= 1'b1;
        end
        DSR_SEL_OPEN: begin
          pos_a <= 1'b1;
          pos_b <= 1'b0;
        end
        default: begin
          pos_a <= 1'b0;
          pos_b <= 1'b0;
        end
      endcase
    end
  end

  assign valid_a   = dsr_valid(filt_a, pos_a);
  assign valid_b   = dsr_valid(filt_b, pos_b);
  assign all_valid = valid_a & valid_b & filt_ok;

  // The counter is wide enough for the largest capacitance setting
  // Timeout length for the selected mode
  always_comb begin
    case (dsr_tmo_e'(timeout_control))
      DSR_TMO_EXT:  tmo_len = CNT_W'(NF_CYC) * CNT_W'(timing_capacitance);
      DSR_TMO_OPEN: tmo_len = CNT_W'(MIN_CYC);
      DSR_TMO_INT:  tmo_len = CNT_W'(INT_CYC);
      default:      tmo_len = CNT_W'(1);
    endcase
  end

  // one-sided hysteresis: valid only after one extra cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmp_hold <= 1'b0;
    end else begin
      cmp_hold <= all_valid;
    end
  end

  // Reset sequencer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state   <= DSR_ST_LOCK;
      tmo_cnt <= '0;
    end else if (!filt_ok) begin
      state   <= DSR_ST_LOCK;
      tmo_cnt <= '0;
    end else if (!all_valid) begin
      state   <= DSR_ST_HOLD;
      tmo_cnt <= '0;
    end else begin
      case (state)
        DSR_ST_LOCK, DSR_ST_HOLD: begin
          tmo_cnt <= '0;
          state   <= DSR_ST_TIME;
        end
        DSR_ST_TIME: begin
          if (tmo_cnt + 1'b1 >= tmo_len) begin
            state <= DSR_ST_RUN;
          end
          tmo_cnt <= tmo_cnt + 1'b1;
        end
        DSR_ST_RUN: tmo_cnt <= '0;
        default:    state   <= DSR_ST_LOCK;
      endcase
    end
  end

  // Outputs leave flops directly so no decode glitch reaches a pin
  // Output flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_out_a <= 1'b0;
      status_out_b <= 1'b0;
      reset_out_n  <= 1'b0;
    end else begin
      // status A; status B, forced low under lockout
      status_out_a <= filt_ok & valid_a;
      status_out_b <= filt_ok & valid_b;
      if (timeout_control == DSR_TMO_CMP) begin
        // comparator mode, release needs two valid cycles
        reset_out_n <= all_valid & cmp_hold;
      end else begin
        // asserted on any invalid; released after timeout
        reset_out_n <= all_valid & (state == DSR_ST_RUN);
      end
    end
  end

  // Event edge detection
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prev_a   <= 1'b0;
      prev_b   <= 1'b0;
      prev_ok  <= 1'b0;
      prev_rst <= 1'b0;
    end else begin
      prev_a   <= status_out_a;
      prev_b   <= status_out_b;
      prev_ok  <= filt_ok;
      prev_rst <= reset_out_n;
    end
  end

  // Edge flops reset to the output reset levels, so no false event follows
  // Falling edges are the events
  assign events = {prev_rst & ~reset_out_n, prev_ok & ~filt_ok,
                   prev_b & ~status_out_b, prev_a & ~status_out_a};

  // Sticky status, read clears, new event wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_stat <= '0;
    end else if (reg_read && reg_addr == REG_IRQ_STAT) begin
      irq_stat <= events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  // Mask register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_mask <= '0;
    end else if (reg_write && reg_addr == REG_IRQ_MASK) begin
      irq_mask <= reg_wdata[IRQ_W-1:0];
    end
  end

  // Interrupt output flop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        REG_CTRL:     reg_rdata <= {28'h0, sel_pin, timeout_control};
        REG_STATUS:   reg_rdata <= {25'h0, state, pos_b, pos_a, reset_out_n,
                                    status_out_b, status_out_a};
        REG_IRQ_STAT: reg_rdata <= {28'h0, irq_stat};
        REG_IRQ_MASK: reg_rdata <= {28'h0, irq_mask};
        REG_CAP:      reg_rdata <= {20'h0, timing_capacitance};
        default:      reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Reset stays asserted while any condition is invalid
  // reset follows invalid input
  inv_rst_a: assert property (@(posedge core_clk) disable iff (reset)
    !all_valid |=> !reset_out_n) else $error("reset released while invalid");

  stat_a_a: assert property (@(posedge core_clk) disable iff (reset)
    status_out_a == $past(filt_ok & valid_a)) else $error("status A wrong");

  stat_b_a: assert property (@(posedge core_clk) disable iff (reset)
    status_out_b == $past(filt_ok & valid_b)) else $error("status B wrong");

  // release only from the run state, outside comparator mode
  rel_run_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(reset_out_n) && $past(timeout_control) != DSR_TMO_CMP
      |-> $past(state) == DSR_ST_RUN) else $error("early release");

  abort_cnt_a: assert property (@(posedge core_clk) disable iff (reset)
    filt_ok && !all_valid |=> tmo_cnt == '0 && state == DSR_ST_HOLD)
    else $error("timeout not aborted");

  lock_out_a: assert property (@(posedge core_clk) disable iff (reset)
    !filt_ok |=> !status_out_a && !status_out_b && !reset_out_n)
    else $error("outputs released in lockout");

  // comparator mode needs two valid cycles to release
  cmp_hyst_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(reset_out_n) && $past(timeout_control) == DSR_TMO_CMP
      |-> $past(all_valid, 2)) else $error("hysteresis skipped");

  // comparator mode releases after two valid cycles
  cmp_pass_a: assert property (@(posedge core_clk) disable iff (reset)
    $past(timeout_control) == DSR_TMO_CMP && $past(all_valid) && $past(all_valid, 2)
      |-> reset_out_n) else $error("comparator mode stuck");

  // internal mode counts the internal timeout before release
  int_len_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(reset_out_n) && $past(timeout_control) == DSR_TMO_INT
      |-> $past(tmo_cnt) == CNT_W'(INT_CYC)) else $error("wrong internal timeout");

  // open control counts the minimum timeout before release
  open_len_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(reset_out_n) && $past(timeout_control) == DSR_TMO_OPEN
      |-> $past(tmo_cnt) == CNT_W'(MIN_CYC)) else $error("wrong minimum timeout");

  // external mode counts the scaled timeout before release
  ext_len_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(reset_out_n) && $past(timeout_control) == DSR_TMO_EXT
      && timing_capacitance != '0
      |-> $past(tmo_cnt) == CNT_W'(NF_CYC) * CNT_W'(timing_capacitance))
    else $error("wrong scaled timeout");
endmodule : dsr_supervisor

// File: verilog/dsr_sync.sv
// Two-flop synchroniser for the three comparator inputs
`timescale 1ns/1ns
module dsr_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Asynchronous comparator results
  input  wire logic above_a_pin,
  input  wire logic above_b_pin,
  input  wire logic supply_ok_pin,
  // Synchronised outputs
  dsr_sync_if.src   sync
);
  logic [2:0] meta;  // First stage, read only by the second
  logic [2:0] stage; // Second stage

  // Two flops per input; reset to the unsafe state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta  <= 3'h0;
      stage <= 3'h0;
    end else begin
      meta  <= {supply_ok_pin, above_b_pin, above_a_pin};
      stage <= meta;
    end
  end

  assign sync.above_a   = stage[0];
  assign sync.above_b   = stage[1];
  assign sync.supply_ok = stage[2];
endmodule : dsr_sync

// File: verilog/dsr_sync_if.sv
// Interface carrying synchronised comparator levels between modules
`timescale 1ns/1ns
interface dsr_sync_if;
  logic above_a;   // Input A above threshold
  logic above_b;   // Input B above threshold
  logic supply_ok; // Supply above lockout
  modport src (output above_a, output above_b, output supply_ok);
  modport dst (input above_a, input above_b, input supply_ok);
endinterface : dsr_sync_if
